// ---- core/lbe_pkg.sv ----
// Constants for the loopback and receive error mask block.
// Assumes a 40 MHz clock and a 32-bit AHB-Lite register bus.
package lbe_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] LBE_OFS_CTRL = 8'h18;
  localparam logic [7:0] LBE_OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0] LBE_OFS_IRQ_MASK = 8'h24;
  // ==========================================================
  // Control register fields
  localparam int LBE_LB_LSB = 8;
  localparam int LBE_CODE_BIT = 4;
  localparam int LBE_PE_BIT = 3;
  localparam int LBE_LINK_BIT = 2;
  localparam int LBE_PKT_BIT = 1;
  localparam logic [1:0] LBE_LB_RESET = 2'h0;
  localparam logic [3:0] LBE_MASK_RESET = 4'h0;
  // ==========================================================
  // Interrupt events, one bit each
  localparam int LBE_NUM_EV = 5;
  localparam int LBE_EV_CODE = 0;
  localparam int LBE_EV_PEND = 1;
  localparam int LBE_EV_LINK = 2;
  localparam int LBE_EV_PKT = 3;
  localparam int LBE_EV_DEAD = 4;
  // ==========================================================
  // Substituted nibbles
  localparam logic [3:0] LBE_NIB_CODE1 = 4'h5;
  localparam logic [3:0] LBE_NIB_PEND1 = 4'h4;
  localparam logic [3:0] LBE_NIB_ERR0 = 4'h6;
  localparam logic [3:0] LBE_NIB_LINK = 4'h3;
  localparam logic [3:0] LBE_NIB_PKT = 4'h2;
  // ==========================================================
  // Timing
  localparam int LBE_CLK_PERIOD_NS = 25;
  localparam int LBE_DEAD_TIME_US = 330;
  localparam int LBE_PKT_TIMEOUT_US = 722;
  localparam int LBE_DEAD_CYCLES = (LBE_DEAD_TIME_US * 1000
    + LBE_CLK_PERIOD_NS - 1) / LBE_CLK_PERIOD_NS;
  localparam int LBE_PKT_CYCLES = (LBE_PKT_TIMEOUT_US * 1000
    + LBE_CLK_PERIOD_NS - 1) / LBE_CLK_PERIOD_NS;
  localparam int LBE_CNT_W = 16;
  // ==========================================================
  // Loopback modes
  typedef enum logic [1:0] {
    LBE_LB_NORMAL = 2'h0,
    LBE_LB_XCVR = 2'h1,
    LBE_LB_REMOTE = 2'h2,
    LBE_LB_RSVD = 2'h3
  } lbe_loop_type;
endpackage : lbe_pkg

// ---- core/lbe_stream_check.sv ----
// Receive symbol stream checker: premature end and packet timeout.
// Assumes decoded symbol flags arrive synchronous to clk.
`timescale 1ns/1ps
module lbe_stream_check #(
  parameter int PKT_CYCLES = lbe_pkg::LBE_PKT_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic symValid,
  input wire logic symStart,
  input wire logic symIdle,
  input wire logic symT,
  input wire logic symR,
  output logic prematureEnd,
  output logic packetTimeout
);
  import lbe_pkg::*;

  logic inPacket;
  logic lastIdle;
  logic lastT;
  logic [LBE_CNT_W-1:0] pktCount;
  logic idlePair;
  logic endDelim;

  // Two idles in a row inside a frame, or T followed by R
  assign idlePair = symValid && symIdle && lastIdle && inPacket;
  assign endDelim = symValid && symR && lastT;

  // ==========================================================
  // Frame tracking
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      inPacket <= 1'b0;
      lastIdle <= 1'b0;
      lastT <= 1'b0;
    end else if (symValid) begin
      lastIdle <= symIdle;
      lastT <= symT;
      if (symStart) begin
        inPacket <= 1'b1;
      end else if (endDelim || idlePair) begin
        inPacket <= 1'b0;
      end
    end
  end

  // Premature end flagged for the symbol that completes the idle pair
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prematureEnd <= 1'b0;
    end else begin
      prematureEnd <= idlePair;
    end
  end

  // Saturating frame length count; timeout holds until the frame ends
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pktCount <= '0;
      packetTimeout <= 1'b0;
    end else if (!inPacket) begin
      pktCount <= '0;
      packetTimeout <= 1'b0;
    end else if (pktCount >= LBE_CNT_W'(PKT_CYCLES - 1)) begin
      packetTimeout <= 1'b1;
    end else begin
      pktCount <= pktCount + LBE_CNT_W'(1);
    end
  end
endmodule : lbe_stream_check

// ---- core/lbe_rx_error_mask.sv ----
// Loopback control and receive error reporting for a 10/100 PHY.
// Assumes an AHB-Lite master with one slave, and receive inputs
// synchronous to clk. Only whole-word transfers are expected, so
// hsize and the upper address bits are not decoded. Dead time and
// packet timeout count clk cycles.
//
// Operation
// - Loopback select resets to 00 (normal); 11 is reserved.
// - Select 01 puts the external transceiver into loopback.
// - Select 10 returns received data to the transmit channel.
// - After entering transceiver loopback, no valid receive data for 330 us.
// - Code error drives RX_ER and nibble 5h if masked on, else 6h.
// - Premature end drives RX_ER and nibble 4h if masked on, else 6h.
// - Two idles before the T/R delimiter mean premature end.
// - Link error mask on gives 3h with RX_ER; off passes data.
// - Packet error mask on gives 2h with RX_ER; off passes data.
// - A packet longer than 722 us is a packet error.
//
// Added by the designer: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module lbe_rx_error_mask #(
  parameter int DEAD_CYCLES = lbe_pkg::LBE_DEAD_CYCLES,
  parameter int PKT_CYCLES = lbe_pkg::LBE_PKT_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Receive side from the decoder
  input wire logic [3:0] rxdIn,
  input wire logic rxDvIn,
  input wire logic codeErrIn,
  input wire logic linkErrIn,
  input wire logic symValid,
  input wire logic symStart,
  input wire logic symIdle,
  input wire logic symT,
  input wire logic symR,
  // MII receive outputs toward the MAC
  output logic [3:0] rxd,
  output logic rxDv,
  output logic rxEr,
  // Remote loopback into the transmit channel
  output logic [3:0] txdLoop,
  output logic txEnLoop,
  // Transceiver loopback control and interrupt request
  output logic xcvrLoopback,
  output logic irq
);
  import lbe_pkg::*;

  // ==========================================================
  // Bus slave state
  logic dataPhase;
  logic dataWrite;
  logic [7:0] dataAddr;
  logic addrTaken;

  // ==========================================================
  // Registers
  // Control word: loopback select in bits 9:8, then one mask bit
  // each for code (4), premature end (3), link (2) and packet (1)
  // errors. Reserved bits are not stored and read back as zero,
  // so a careless write of ones there cannot change behaviour.
  // Status and mask words share one layout, one bit per event.
  logic [1:0] loopbackSelect;
  logic codeErrorMask;
  logic prematureEndMask;
  logic linkErrorMask;
  logic packetErrorMask;
  logic [LBE_NUM_EV-1:0] irqStatus;
  logic [LBE_NUM_EV-1:0] irqMask;
  logic [LBE_NUM_EV-1:0] evSet;
  logic [LBE_NUM_EV-1:0] evClr;

  // ==========================================================
  // Receive path state
  logic prematureEnd;
  logic packetTimeout;
  logic [LBE_CNT_W-1:0] deadCount;
  logic deadActive;
  logic deadDone;
  logic [1:0] prevSelect;
  logic enterXcvr;
  logic [3:0] next_rxd;
  logic next_rxEr;
  logic next_rxDv;

  // Write strobe to a given register in the data phase
  function automatic logic wrHit(input logic [7:0] ofs);
    wrHit = dataPhase && dataWrite && (dataAddr == ofs);
  endfunction : wrHit

  // Read value of the control register; reserved bits read zero
  function automatic logic [31:0] ctrlWord();
    logic [31:0] w;
    w = '0;
    w[LBE_LB_LSB +: 2] = loopbackSelect;
    w[LBE_CODE_BIT] = codeErrorMask;
    w[LBE_PE_BIT] = prematureEndMask;
    w[LBE_LINK_BIT] = linkErrorMask;
    w[LBE_PKT_BIT] = packetErrorMask;
    ctrlWord = w;
  endfunction : ctrlWord

  // Mode decodes; the transceiver control and the dead-time edge
  // detect both need the first, so it lives in one place
  function automatic logic isXcvr(input logic [1:0] sel);
    isXcvr = (sel == LBE_LB_XCVR);
  endfunction : isXcvr

  function automatic logic isRemote(input logic [1:0] sel);
    isRemote = (sel == LBE_LB_REMOTE);
  endfunction : isRemote

  // ==========================================================
  // Address phase accepted on an active NONSEQ or SEQ transfer
  assign addrTaken = hsel && htrans[1] && hready;

  // One wait state per transfer keeps read data a clean flop
  // output and lets a write land before a following read samples.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dataPhase <= 1'b0;
      dataWrite <= 1'b0;
      dataAddr <= 8'h00;
    end else if (addrTaken) begin
      dataPhase <= 1'b1;
      dataWrite <= hwrite;
      dataAddr <= haddr[7:0];
    end else begin
      dataPhase <= 1'b0;
    end
  end

  // Ready drops for the first data phase cycle only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= !addrTaken;
    end
  end

  // No transfer is ever refused, so the response stays OKAY
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // Read data captured in the wait cycle; unmapped reads give zero
  // and are still answered OKAY, so a probe of a wrong address
  // cannot hang the bus.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hrdata <= 32'h0000_0000;
    end else if (dataPhase && !dataWrite) begin
      case (dataAddr)
        LBE_OFS_CTRL: hrdata <= ctrlWord();
        LBE_OFS_IRQ_STAT: hrdata <= 32'(irqStatus);
        LBE_OFS_IRQ_MASK: hrdata <= 32'(irqMask);
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Control register; reserved bits are not stored
  // A write of select 11 is kept; the mode logic treats it as normal.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      loopbackSelect <= LBE_LB_RESET;
      codeErrorMask <= LBE_MASK_RESET[0];
      prematureEndMask <= LBE_MASK_RESET[1];
      linkErrorMask <= LBE_MASK_RESET[2];
      packetErrorMask <= LBE_MASK_RESET[3];
    end else if (wrHit(LBE_OFS_CTRL)) begin
      loopbackSelect <= hwdata[LBE_LB_LSB +: 2];
      codeErrorMask <= hwdata[LBE_CODE_BIT];
      prematureEndMask <= hwdata[LBE_PE_BIT];
      linkErrorMask <= hwdata[LBE_LINK_BIT];
      packetErrorMask <= hwdata[LBE_PKT_BIT];
    end
  end

  // ==========================================================
  // Interrupt mask
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irqMask <= '0;
    end else if (wrHit(LBE_OFS_IRQ_MASK)) begin
      irqMask <= hwdata[LBE_NUM_EV-1:0];
    end
  end

  // Events that raise sticky status
  assign evSet[LBE_EV_CODE] = codeErrIn && rxDvIn;
  assign evSet[LBE_EV_PEND] = prematureEnd;
  assign evSet[LBE_EV_LINK] = linkErrIn;
  assign evSet[LBE_EV_PKT] = packetTimeout;
  assign evSet[LBE_EV_DEAD] = deadDone;
  assign evClr = wrHit(LBE_OFS_IRQ_STAT) ? hwdata[LBE_NUM_EV-1:0] : '0;

  // Write-one-to-clear; a set in the same cycle wins over the clear
  for (genvar i = 0; i < LBE_NUM_EV; i++) begin : g_stat
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        irqStatus[i] <= 1'b0;
      end else if (evSet[i]) begin
        irqStatus[i] <= 1'b1;
      end else if (evClr[i]) begin
        irqStatus[i] <= 1'b0;
      end
    end
  end

  // Level interrupt from unmasked status
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatus & irqMask);
    end
  end

  // ==========================================================
  // Stream checks. Frame tracking lives in its own block so the
  // long timeout counter stays apart from the bus and mask logic.
  lbe_stream_check #(
    .PKT_CYCLES(PKT_CYCLES)
  ) u_check (
    .clk(clk),
    .nrst(nrst),
    .symValid(symValid),
    .symStart(symStart),
    .symIdle(symIdle),
    .symT(symT),
    .symR(symR),
    .prematureEnd(prematureEnd),
    .packetTimeout(packetTimeout)
  );

  // ==========================================================
  // Transceiver loopback control; reserved code 11 acts as normal
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      xcvrLoopback <= 1'b0;
    end else begin
      xcvrLoopback <= isXcvr(loopbackSelect);
    end
  end

  // Remote loopback copy; held at zero in every other mode so the
  // transmit channel never picks up stray receive data
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      txdLoop <= 4'h0;
      txEnLoop <= 1'b0;
    end else if (isRemote(loopbackSelect)) begin
      txdLoop <= rxdIn;
      txEnLoop <= rxDvIn;
    end else begin
      txdLoop <= 4'h0;
      txEnLoop <= 1'b0;
    end
  end

  // ==========================================================
  // Dead time after entering transceiver loopback
  // Leaving transceiver loopback early does not cut the dead time
  // short: the count runs out and still raises its status bit.
  assign enterXcvr = isXcvr(loopbackSelect) && !isXcvr(prevSelect);
  assign deadActive = (deadCount != '0);
  assign deadDone = (deadCount == LBE_CNT_W'(1));

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prevSelect <= LBE_LB_RESET;
      deadCount <= '0;
    end else begin
      prevSelect <= loopbackSelect;
      if (enterXcvr) begin
        deadCount <= LBE_CNT_W'(DEAD_CYCLES);
      end else if (deadActive) begin
        deadCount <= deadCount - LBE_CNT_W'(1);
      end
    end
  end

  // ==========================================================
  // Error substitution; code error outranks premature end,
  // then link, then packet errors. Only one nibble can stand in
  // a cycle, so a lower-ranked error that coincides is reported
  // through its status bit alone.
  always_comb begin
    next_rxd = rxdIn;
    next_rxDv = rxDvIn;
    next_rxEr = 1'b0;
    if (deadActive || enterXcvr) begin
      next_rxd = 4'h0;
      next_rxDv = 1'b0;
    end else if (codeErrIn) begin
      next_rxEr = 1'b1;
      next_rxd = codeErrorMask ? LBE_NIB_CODE1 : LBE_NIB_ERR0;
    end else if (prematureEnd) begin
      next_rxEr = 1'b1;
      next_rxd = prematureEndMask ? LBE_NIB_PEND1 : LBE_NIB_ERR0;
    end else if (linkErrIn && linkErrorMask) begin
      next_rxEr = 1'b1;
      next_rxd = LBE_NIB_LINK;
    end else if (packetTimeout && packetErrorMask) begin
      next_rxEr = 1'b1;
      next_rxd = LBE_NIB_PKT;
    end
  end

  // Registered MII receive outputs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rxd <= 4'h0;
      rxDv <= 1'b0;
      rxEr <= 1'b0;
    end else begin
      rxd <= next_rxd;
      rxDv <= next_rxDv;
      rxEr <= next_rxEr;
    end
  end
endmodule : lbe_rx_error_mask

// ---- test/lbe_rx_error_mask_asserts.sv ----
// Concurrent checks on the ports of the receive error mask block.
// Assumes one clock domain and the bench holding dead time short.
`timescale 1ns/1ps
module lbe_rx_error_mask_asserts
  import lbe_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [3:0] rxdIn,
  input wire logic rxDvIn,
  input wire logic codeErrIn,
  input wire logic linkErrIn,
  input wire logic [3:0] rxd,
  input wire logic rxDv,
  input wire logic rxEr,
  input wire logic [3:0] txdLoop,
  input wire logic txEnLoop,
  input wire logic xcvrLoopback
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_bus_wait: assert property (
    hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout)
    else $error("data phase is not two cycles");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  a_code_nib: assert property (
    codeErrIn && !xcvrLoopback |=> rxEr &&
    (rxd == LBE_NIB_CODE1 || rxd == LBE_NIB_ERR0))
    else $error("code error not reported");
  a_err_nibble: assert property (
    rxEr |-> rxd inside {[4'h2:4'h6]})
    else $error("error flagged with plain data");
  a_link_cause: assert property (
    rxEr && rxd == LBE_NIB_LINK |-> $past(linkErrIn))
    else $error("link nibble without link error");
  a_loop_copy: assert property (
    txEnLoop |-> $past(rxDvIn) && txdLoop == $past(rxdIn) && !xcvrLoopback)
    else $error("remote loopback copy wrong");
  a_dv_follow: assert property (
    !xcvrLoopback && !$past(xcvrLoopback) |-> rxDv == $past(rxDvIn))
    else $error("receive valid does not follow");
  a_dead_quiet: assert property (
    $rose(xcvrLoopback) |-> (!rxDv && !rxEr) ##1 (!rxDv && !rxEr)[*8])
    else $error("data during dead time");
  a_ready_back: assert property (!hreadyout |=> hreadyout)
    else $error("wait state too long");
endmodule : lbe_rx_error_mask_asserts

// ---- test/lbe_mac_model.sv ----
// Receiving MAC model: watches the MII receive outputs.
// Assumes receive outputs registered on clk.
`timescale 1ns/1ps
module lbe_mac_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] rxd,
  input wire logic rxEr,
  output logic [3:0] lastErrNib,
  output logic [15:0] errCycles
);
  // ==========================================================
  // Error capture: every flagged cycle counts, so a held error shows
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lastErrNib <= 4'h0;
      errCycles <= 16'h0000;
    end else if (rxEr) begin
      lastErrNib <= rxd;
      errCycles <= errCycles + 16'h0001;
    end
  end
endmodule : lbe_mac_model

// ---- test/tb_top.sv ----
// Self-checking bench for the receive error mask block.
// Assumes a single AHB-Lite slave and a shortened dead time and timeout.
`timescale 1ns/1ps
module tb_top;
  import lbe_pkg::*;
  localparam int DEAD = 20;
  localparam int PKT = 30;
  logic clk = 0, nrst = 0, hsel = 0, hwrite = 0, hready;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [3:0] rxdIn = 0, rxd, txdLoop, lastErrNib;
  logic rxDvIn = 0, codeErrIn = 0, linkErrIn = 0, symValid = 0;
  logic symStart = 0, symIdle = 0, symT = 0, symR = 0;
  logic hreadyout, hresp, rxDv, rxEr, txEnLoop, xcvrLoopback, irq;
  logic [15:0] errCycles;
  int num_errors = 0, compares = 0, cyc = 0, n;
  assign hready = hreadyout;
  always #12.5 clk = ~clk;
  lbe_rx_error_mask #(.DEAD_CYCLES(DEAD), .PKT_CYCLES(PKT))
    lbe_rx_error_mask_inst (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .rxdIn, .rxDvIn,
    .codeErrIn, .linkErrIn, .symValid, .symStart, .symIdle, .symT, .symR,
    .rxd, .rxDv, .rxEr, .txdLoop, .txEnLoop, .xcvrLoopback, .irq);
  lbe_mac_model lbe_mac_model_inst (.clk, .nrst, .rxd, .rxEr, .lastErrNib,
    .errCycles);
  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] got, exp, input string what);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  // One single transfer; waits on hready, never on a fixed count
  task automatic bus(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus
  function automatic logic [31:0] ctl(input logic [1:0] s,
    input logic [3:0] m);
    return {22'h00_0000, s, 3'h0, m, 1'b0}; // reserved written zero
  endfunction : ctl
  task automatic rx(input logic [3:0] d, input logic dv, ce, le);
    @(posedge clk);
    rxdIn <= d;
    rxDvIn <= dv;
    codeErrIn <= ce;
    linkErrIn <= le;
  endtask : rx
  task automatic sym(input logic v, s, i, t, r);
    @(posedge clk);
    {symValid, symStart, symIdle, symT, symR} <= {v, s, i, t, r};
  endtask : sym
  task automatic expect_rx(input logic [3:0] d, input logic e, string w);
    @(posedge clk);
    #1 check({rxd, rxEr}, {d, e}, w);
  endtask : expect_rx
  task automatic close_frame();
    sym(1, 0, 0, 1, 0);
    sym(1, 0, 0, 0, 1);
    sym(0, 0, 0, 0, 0);
    rx(4'h0, 0, 0, 0);
    repeat (3) @(posedge clk);
  endtask : close_frame
  // ==========================================================
  // Scenarios
  task automatic test_reset();
    bus(0, LBE_OFS_CTRL, 0, q);
    check(q, 32'h0000_0000, "control reset");
    bus(1, 8'h40, 32'hFFFF_FFFF, q);
    bus(0, 8'h40, 0, q);
    check(q, 32'h0000_0000, "unmapped read");
    bus(1, LBE_OFS_CTRL, ctl(2'h2, 4'hF), q);
    bus(0, LBE_OFS_CTRL, 0, q);
    check(q, ctl(2'h2, 4'hF), "control readback");
    $display("test_reset done");
  endtask : test_reset
  task automatic test_errors(input logic m);
    bus(1, LBE_OFS_CTRL, ctl(2'h0, {4{m}}), q);
    n = errCycles;
    rx(4'h9, 1, 1, 0);
    expect_rx(m ? 4'h5 : 4'h6, 1, "code nibble");
    expect_rx(m ? 4'h5 : 4'h6, 1, "code held");
    check(lastErrNib, m ? 4'h5 : 4'h6, "mac saw code");
    check(errCycles, n + 1, "mac error count");
    rx(4'hA, 1, 0, 1);
    expect_rx(m ? 4'h3 : 4'hA, m, "link nibble");
    rx(4'hB, 1, 0, 0);
    sym(1, 1, 0, 0, 0);
    sym(1, 0, 1, 0, 0);
    sym(1, 0, 1, 0, 0);
    sym(0, 0, 0, 0, 0);
    n = 0;
    do begin
      @(posedge clk);
      #1;
    end while (rxEr !== 1'b1 && ++n < 6);
    check(rxd, m ? 4'h4 : 4'h6, "premature end");
    close_frame();
    sym(1, 1, 0, 0, 0);
    sym(0, 0, 0, 0, 0);
    rx(4'hC, 1, 0, 0);
    repeat (PKT + 5) @(posedge clk);
    #1 check({rxd, rxEr}, {m ? 4'h2 : 4'hC, m}, "packet");
    close_frame();
    #1 check(rxEr, 1'b0, "frame closed");
    $display("test_errors done");
  endtask : test_errors
  task automatic test_irq();
    bus(0, LBE_OFS_IRQ_STAT, 0, q);
    check(q[LBE_EV_CODE], 1'b1, "code status");
    check(irq, 1'b0, "masked irq");
    bus(1, LBE_OFS_IRQ_MASK, 32'h0000_0001, q);
    #1 check(irq, 1'b1, "unmasked irq");
    bus(1, LBE_OFS_IRQ_STAT, 32'h0000_001F, q);
    bus(0, LBE_OFS_IRQ_STAT, 0, q);
    check(irq, 1'b0, "cleared irq");
    $display("test_irq done");
  endtask : test_irq
  task automatic test_remote();
    bus(1, LBE_OFS_CTRL, ctl(2'h2, 4'h0), q);
    rx(4'h7, 1, 0, 0);
    @(posedge clk);
    #1 check({txdLoop, txEnLoop, xcvrLoopback}, 6'h1E, "remote");
    bus(1, LBE_OFS_CTRL, ctl(2'h0, 4'h0), q);
    #1 check(txEnLoop, 1'b0, "remote off");
    $display("test_remote done");
  endtask : test_remote
  task automatic test_dead();
    bus(1, LBE_OFS_IRQ_MASK, 32'h0000_0010, q);
    rx(4'h5, 1, 0, 0);
    bus(1, LBE_OFS_CTRL, ctl(2'h1, 4'h0), q);
    #1 check(xcvrLoopback, 1'b1, "transceiver loop");
    n = 0;
    while (rxDv !== 1'b1 && n < DEAD + 20) begin
      @(posedge clk);
      #1 n++;
    end
    check(n, DEAD + 1, "dead length");
    check(rxd, 4'h5, "data after dead");
    check(irq, 1'b1, "dead irq");
    bus(1, LBE_OFS_IRQ_STAT, 32'h0000_0010, q);
    bus(1, LBE_OFS_CTRL, ctl(2'h0, 4'h0), q);
    check(irq, 1'b0, "dead irq cleared");
    $display("test_dead done");
  endtask : test_dead
  // ==========================================================
  // Watchdog and main sequence
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      $display("MISMATCH %0t timeout", $time);
      tally_and_finish();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1;
    test_reset();
    test_errors(1'b1);
    test_errors(1'b0);
    test_irq();
    test_remote();
    test_dead();
    tally_and_finish();
  end
endmodule : tb_top
bind lbe_rx_error_mask lbe_rx_error_mask_asserts
  lbe_rx_error_mask_asserts_inst (.clk, .nrst, .hsel, .htrans, .hready,
  .hreadyout, .hresp, .rxdIn, .rxDvIn, .codeErrIn, .linkErrIn, .rxd, .rxDv,
  .rxEr, .txdLoop, .txEnLoop, .xcvrLoopback);
